// >>> verilog/rsx_params.svh
`ifndef RSX_PARAMS_SVH
`define RSX_PARAMS_SVH

// Register byte offsets on the AHB-Lite port
`define RSX_ACC_OFS        32'h0000_0000
`define RSX_STATUS_OFS     32'h0000_0004
`define RSX_RESULT_OFS     32'h0000_0008

// Status register field positions
`define RSX_CARRY_BIT      0
`define RSX_HALF_BIT       1
`define RSX_ZERO_BIT       2
`define RSX_OVF_BIT        3
`define RSX_MIE_BIT        4

// Reset values
`define RSX_ACC_RST        8'h00
`define RSX_FLAG_RST       1'b0
`define RSX_MIE_RST        1'b0

// Fixed data values
`define RSX_ALL_ONES       8'hff
`define RSX_BYTE_ZERO      8'h00
`define RSX_BYTE_ONE       8'h01
`define RSX_UNMAPPED_RD    32'h0000_0000

`endif

// >>> verilog/rsx_pkg.sv
`default_nettype none
package rsx_pkg;

   // Instructions this datapath executes
   typedef enum logic [4:0] {
      OP_CALL_EXIT_LOAD_LITERAL,
      OP_INTERRUPT_EXIT,
      OP_MEMORY_ROTATE_LEFT,
      OP_ACC_ROTATE_LEFT,
      OP_MEMORY_ROTATE_LEFT_CARRY,
      OP_ACC_ROTATE_LEFT_CARRY,
      OP_MEMORY_ROTATE_RIGHT,
      OP_ACC_ROTATE_RIGHT,
      OP_MEMORY_ROTATE_RIGHT_THRU_CY,
      OP_ACC_ROTATE_RIGHT_THRU_CY,
      OP_MINUS_WITH_BORROW_TO_ACC,
      OP_MINUS_WITH_BORROW_TO_MEM,
      OP_MINUS_MEMORY_TO_ACC,
      OP_MINUS_MEMORY_TO_MEM,
      OP_MINUS_LITERAL_TO_ACC,
      OP_DECREMENT_SKIP_ZERO,
      OP_DECREMENT_TO_ACC_SKIP_ZERO,
      OP_INCREMENT_SKIP_ZERO,
      OP_INCREMENT_TO_ACC_SKIP_ZERO,
      OP_SKIP_BIT_NONZERO,
      OP_SET_ALL,
      OP_SET_BIT,
      OP_NIBBLE_SWAP
   } rsx_op_t;

   // Issue slot state
   typedef enum logic {
      ST_EXEC,
      ST_DUMMY
   } rsx_state_t;

endpackage : rsx_pkg
`default_nettype wire

// >>> verilog/rsx_exec.sv
// Notes on behaviour
// (RULE1) Literal return: pop PC, load ACC, flags kept
// (RULE2) Interrupt exit: pop PC, set master enable
// (RULE3) Pending interrupt serviced before main resumes
// (RULE4) Rotate left, bit 7 into bit 0
// (RULE5) Rotate left through carry, nine-bit loop
// (RULE6) Rotate right, bit 0 into bit 7
// (RULE7) Rotate right through carry, nine-bit loop
// (RULE8) Borrow subtract: ACC minus operand minus not-C
// (RULE9) Subtract: C means no borrow; OV, Z, AC
// (RULE10) Plain subtract of memory or literal
// (RULE11) Decrement memory, skip when result zero
// (RULE12) Increment memory, skip when result zero
// (RULE13) ACC forms keep memory, skip on zero
// (RULE14) Taken skip adds one dummy slot
// (RULE15) Skip when selected memory bit is one
// (RULE16) Set-all writes all ones, flags kept
// (RULE17) Set-bit forces one bit only
// (RULE18) Nibble swap written back to memory
// (RULE19) Eight-bit data, flags commit with result
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`include "rsx_params.svh"
`default_nettype none

module rsx_exec
   import rsx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   // Issue port from the instruction sequencer
   input  wire logic        issue_valid,
   input  wire rsx_op_t     issue_op,
   input  wire logic [7:0]  issue_imm,
   input  wire logic [2:0]  issue_bit,
   input  wire logic [7:0]  issue_addr,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        irq_pending,
   output logic             issue_ready_ff,
   output logic             mem_we_ff,
   output logic [7:0]       mem_waddr_ff,
   output logic [7:0]       mem_wdata_ff,
   output logic             pop_pc_ff,
   output logic             skip_ff,
   output logic             irq_service_ff,
   output logic [7:0]       acc_ff,
   output logic             master_irq_enable_ff,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout_ff,
   output logic [31:0]      hrdata_ff,
   output logic             hresp_ff
);

   // Flag registers; carry set means no borrow
   logic        carry_ff;
   logic        half_carry_flag_ff, zero_ff, overflow_flag_ff;
   logic [7:0]  result_ff;         // Last computed result
   rsx_state_t  state_ff;          // Issue slot, dummy after a skip
   // Bus pipeline registers
   logic        wr_pend_ff, rd_pend_ff;
   logic [31:0] wr_addr_ff, rd_addr_ff;
   // Datapath decode outputs
   logic [7:0]  res;
   logic        wr_acc, wr_mem, upd_c, new_c;
   logic        upd_arith, skip_cond, do_pop, irq_exit;
   // Subtract operands and raw results
   logic [7:0]  sub_b;
   logic [8:0]  sub_full;          // Top bit is the borrow out
   logic [4:0]  sub_low;           // Top bit is the nibble borrow
   logic        sub_cin, sub_ovf;

   wire        take     = issue_valid && issue_ready_ff;
   wire [7:0]  bit_mask = `RSX_BYTE_ONE << issue_bit;
   wire [7:0]  dec_val  = mem_rdata - `RSX_BYTE_ONE;
   wire [7:0]  inc_val  = mem_rdata + `RSX_BYTE_ONE;
   wire        is_sbc   = (issue_op == OP_MINUS_WITH_BORROW_TO_ACC) ||
                          (issue_op == OP_MINUS_WITH_BORROW_TO_MEM);

   // (RULE8) Borrow enters as inverted carry
   assign sub_b    = (issue_op == OP_MINUS_LITERAL_TO_ACC) ? issue_imm
                                                            : mem_rdata;
   assign sub_cin  = is_sbc ? ~carry_ff : 1'b0;
   // (RULE9) Nine-bit difference exposes the borrow
   assign sub_full = {1'b0, acc_ff} - {1'b0, sub_b} - {8'h00, sub_cin};
   assign sub_low  = {1'b0, acc_ff[3:0]} - {1'b0, sub_b[3:0]}
                     - {4'h0, sub_cin};
   assign sub_ovf  = (acc_ff[7] != sub_b[7]) && (sub_full[7] != acc_ff[7]);

   // Bus address phase qualifiers
   wire addr_ok  = hsel && htrans[1] && hready;
   wire bus_wr   = addr_ok && hwrite;
   wire bus_rd   = addr_ok && !hwrite;
   wire wr_acc_r = wr_pend_ff && (wr_addr_ff == `RSX_ACC_OFS);
   wire wr_sts_r = wr_pend_ff && (wr_addr_ff == `RSX_STATUS_OFS);

   // Per-instruction result and side effects
   always_comb
   begin
      res       = `RSX_BYTE_ZERO;
      wr_acc    = 1'b0;
      wr_mem    = 1'b0;
      upd_c     = 1'b0;
      new_c     = carry_ff;
      upd_arith = 1'b0;
      skip_cond = 1'b0;
      do_pop    = 1'b0;
      irq_exit  = 1'b0;
      unique case (issue_op)
         // (RULE1) Pop and literal load
         OP_CALL_EXIT_LOAD_LITERAL:
         begin
            res    = issue_imm;
            wr_acc = 1'b1;
            do_pop = 1'b1;
         end
         // (RULE2) Pop, enable set below
         OP_INTERRUPT_EXIT:
         begin
            do_pop   = 1'b1;
            irq_exit = 1'b1;
         end
         // (RULE4) Plain left rotate
         OP_MEMORY_ROTATE_LEFT, OP_ACC_ROTATE_LEFT:
         begin
            res    = {mem_rdata[6:0], mem_rdata[7]};
            wr_mem = (issue_op == OP_MEMORY_ROTATE_LEFT);
            wr_acc = !wr_mem;
         end
         // (RULE5) Left through carry
         OP_MEMORY_ROTATE_LEFT_CARRY, OP_ACC_ROTATE_LEFT_CARRY:
         begin
            res    = {mem_rdata[6:0], carry_ff};
            new_c  = mem_rdata[7];
            upd_c  = 1'b1;
            wr_mem = (issue_op == OP_MEMORY_ROTATE_LEFT_CARRY);
            wr_acc = !wr_mem;
         end
         // (RULE6) Plain right rotate
         OP_MEMORY_ROTATE_RIGHT, OP_ACC_ROTATE_RIGHT:
         begin
            res    = {mem_rdata[0], mem_rdata[7:1]};
            wr_mem = (issue_op == OP_MEMORY_ROTATE_RIGHT);
            wr_acc = !wr_mem;
         end
         // (RULE7) Right through carry
         OP_MEMORY_ROTATE_RIGHT_THRU_CY, OP_ACC_ROTATE_RIGHT_THRU_CY:
         begin
            res    = {carry_ff, mem_rdata[7:1]};
            new_c  = mem_rdata[0];
            upd_c  = 1'b1;
            wr_mem = (issue_op == OP_MEMORY_ROTATE_RIGHT_THRU_CY);
            wr_acc = !wr_mem;
         end
         // (RULE8) (RULE10) All subtract forms share one path
         OP_MINUS_WITH_BORROW_TO_ACC, OP_MINUS_WITH_BORROW_TO_MEM,
         OP_MINUS_MEMORY_TO_ACC, OP_MINUS_MEMORY_TO_MEM,
         OP_MINUS_LITERAL_TO_ACC:
         begin
            res       = sub_full[7:0];
            new_c     = ~sub_full[8];
            upd_c     = 1'b1;
            upd_arith = 1'b1;
            wr_mem    = (issue_op == OP_MINUS_WITH_BORROW_TO_MEM) ||
                        (issue_op == OP_MINUS_MEMORY_TO_MEM);
            wr_acc    = !wr_mem;
         end
         // (RULE11) (RULE13) Decrement into memory or ACC
         OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_TO_ACC_SKIP_ZERO:
         begin
            res       = dec_val;
            wr_mem    = (issue_op == OP_DECREMENT_SKIP_ZERO);
            wr_acc    = !wr_mem;
            skip_cond = (dec_val == `RSX_BYTE_ZERO);
         end
         // (RULE12) (RULE13) Increment into memory or ACC
         OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_TO_ACC_SKIP_ZERO:
         begin
            res       = inc_val;
            wr_mem    = (issue_op == OP_INCREMENT_SKIP_ZERO);
            wr_acc    = !wr_mem;
            skip_cond = (inc_val == `RSX_BYTE_ZERO);
         end
         // (RULE15) Bit test, nothing written
         OP_SKIP_BIT_NONZERO:
         begin
            res       = mem_rdata;
            skip_cond = |(mem_rdata & bit_mask);
         end
         // (RULE16) All ones
         OP_SET_ALL:
         begin
            res    = `RSX_ALL_ONES;
            wr_mem = 1'b1;
         end
         // (RULE17) One bit forced high
         OP_SET_BIT:
         begin
            res    = mem_rdata | bit_mask;
            wr_mem = 1'b1;
         end
         // (RULE18) Nibbles exchanged in place
         OP_NIBBLE_SWAP:
         begin
            res    = {mem_rdata[3:0], mem_rdata[7:4]};
            wr_mem = 1'b1;
         end
         // Unused codes act as a no-op: nothing written
         default:
         begin
            res = `RSX_BYTE_ZERO;
         end
      endcase
   end

   // Next values for datapath state
   wire       skip_now = take && skip_cond;
   wire [7:0] nxt_acc  = (take && wr_acc) ? res
                       : wr_acc_r ? hwdata[7:0] : acc_ff;
   // (RULE14) Dummy slot follows a taken skip
   wire rsx_state_t nxt_state = skip_now ? ST_DUMMY : ST_EXEC;

   // Accumulator and slot state; instruction beats a bus write
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         acc_ff         <= `RSX_ACC_RST;
         state_ff       <= ST_EXEC;
         issue_ready_ff <= 1'b1;
      end
      else
      begin
         acc_ff         <= nxt_acc;
         state_ff       <= nxt_state;
         issue_ready_ff <= (nxt_state == ST_EXEC);
      end
   end

   // (RULE19) Flags commit on the same edge as the result
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         carry_ff             <= `RSX_FLAG_RST;
         half_carry_flag_ff   <= `RSX_FLAG_RST;
         zero_ff              <= `RSX_FLAG_RST;
         overflow_flag_ff     <= `RSX_FLAG_RST;
         master_irq_enable_ff <= `RSX_MIE_RST;
      end
      else
      begin
         if (take && upd_c)
            carry_ff <= new_c;
         else if (wr_sts_r)
            carry_ff <= hwdata[`RSX_CARRY_BIT];
         // (RULE9) AC, Z and OV only from subtracts
         if (take && upd_arith)
         begin
            half_carry_flag_ff <= ~sub_low[4];
            zero_ff            <= (sub_full[7:0] == `RSX_BYTE_ZERO);
            overflow_flag_ff   <= sub_ovf;
         end
         else if (wr_sts_r)
         begin
            half_carry_flag_ff <= hwdata[`RSX_HALF_BIT];
            zero_ff            <= hwdata[`RSX_ZERO_BIT];
            overflow_flag_ff   <= hwdata[`RSX_OVF_BIT];
         end
         // (RULE2) Interrupt exit forces enable high
         if (take && irq_exit)
            master_irq_enable_ff <= 1'b1;
         else if (wr_sts_r)
            master_irq_enable_ff <= hwdata[`RSX_MIE_BIT];
      end
   end

   // Strobes towards memory, stack and sequencer
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         mem_we_ff      <= 1'b0;
         mem_waddr_ff   <= `RSX_BYTE_ZERO;
         mem_wdata_ff   <= `RSX_BYTE_ZERO;
         result_ff      <= `RSX_BYTE_ZERO;
         pop_pc_ff      <= 1'b0;
         skip_ff        <= 1'b0;
         irq_service_ff <= 1'b0;
      end
      else
      begin
         mem_we_ff      <= take && wr_mem;
         mem_waddr_ff   <= take ? issue_addr : mem_waddr_ff;
         mem_wdata_ff   <= take ? res : mem_wdata_ff;
         result_ff      <= take ? res : result_ff;
         pop_pc_ff      <= take && do_pop;
         skip_ff        <= skip_now;
         // (RULE3) Vector to pending interrupt before resuming
         irq_service_ff <= take && irq_exit && irq_pending;
      end
   end

   // Read mux, sampled one cycle after the address phase
   wire [31:0] rd_mux =
      (rd_addr_ff == `RSX_ACC_OFS)    ? {24'h000000, acc_ff} :
      (rd_addr_ff == `RSX_STATUS_OFS) ? {27'h0000000, master_irq_enable_ff,
                                         overflow_flag_ff, zero_ff,
                                         half_carry_flag_ff, carry_ff} :
      (rd_addr_ff == `RSX_RESULT_OFS) ? {24'h000000, result_ff} :
      `RSX_UNMAPPED_RD;

   // AHB-Lite slave: writes zero-wait, reads one wait state
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wr_pend_ff   <= 1'b0;
         wr_addr_ff   <= 32'h0000_0000;
         rd_pend_ff   <= 1'b0;
         rd_addr_ff   <= 32'h0000_0000;
         hreadyout_ff <= 1'b1;
         hrdata_ff    <= 32'h0000_0000;
         hresp_ff     <= 1'b0;
      end
      else
      begin
         wr_pend_ff   <= bus_wr;
         wr_addr_ff   <= bus_wr ? haddr : wr_addr_ff;
         rd_pend_ff   <= bus_rd;
         rd_addr_ff   <= bus_rd ? haddr : rd_addr_ff;
         // Wait state lets a just-written value reach the mux
         hreadyout_ff <= !bus_rd;
         hrdata_ff    <= rd_pend_ff ? rd_mux : hrdata_ff;
         hresp_ff     <= 1'b0;
      end
   end

   // Checks on the datapath
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_lit_return: assert property ( // (RULE1)
      take && issue_op == OP_CALL_EXIT_LOAD_LITERAL |=>
      pop_pc_ff && acc_ff == $past(issue_imm)
      && carry_ff == $past(carry_ff))
      else $error("literal return failed");
   a_irq_exit_mie: assert property ( // (RULE2)
      take && issue_op == OP_INTERRUPT_EXIT |=>
      master_irq_enable_ff && pop_pc_ff)
      else $error("interrupt exit did not set enable");
   a_irq_pending_svc: assert property ( // (RULE3)
      take && issue_op == OP_INTERRUPT_EXIT && irq_pending |=>
      irq_service_ff)
      else $error("pending interrupt not serviced");
   a_rot_left_mem: assert property ( // (RULE4)
      take && issue_op == OP_MEMORY_ROTATE_LEFT |=>
      mem_we_ff && mem_wdata_ff == {$past(mem_rdata[6:0]),
                                    $past(mem_rdata[7])})
      else $error("rotate left wrong");
   a_rot_lc_carry: assert property ( // (RULE5)
      take && issue_op == OP_ACC_ROTATE_LEFT_CARRY |=>
      carry_ff == $past(mem_rdata[7]) && acc_ff[0] == $past(carry_ff)
      && !mem_we_ff)
      else $error("rotate left carry wrong");
   a_rot_rc_carry: assert property ( // (RULE7)
      take && issue_op == OP_MEMORY_ROTATE_RIGHT_THRU_CY |=>
      carry_ff == $past(mem_rdata[0]) && mem_wdata_ff[7] == $past(carry_ff))
      else $error("rotate right carry wrong");
   a_sub_carry: assert property ( // (RULE9)
      take && issue_op == OP_MINUS_MEMORY_TO_ACC |=>
      carry_ff == ($past(acc_ff) >= $past(mem_rdata)))
      else $error("subtract carry wrong");
   a_skip_dummy: assert property ( // (RULE14)
      take && skip_cond |=> skip_ff && !issue_ready_ff
      && state_ff == ST_DUMMY ##1 issue_ready_ff)
      else $error("skip slot wrong");
   a_set_all: assert property ( // (RULE16)
      take && issue_op == OP_SET_ALL |=>
      mem_we_ff && mem_wdata_ff == `RSX_ALL_ONES)
      else $error("set all wrong");
   a_swap_mem: assert property ( // (RULE18)
      take && issue_op == OP_NIBBLE_SWAP |=>
      mem_wdata_ff == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
      else $error("swap wrong");

   c_skip_taken: cover property (take && skip_cond ##1 skip_ff);
   c_irq_svc: cover property (irq_service_ff);
   c_borrow_sub: cover property (take && is_sbc && !carry_ff);
   c_bus_read: cover property (rd_pend_ff ##1 hreadyout_ff);

endmodule : rsx_exec
`default_nettype wire

// >>> dv/rsx_mem_model.sv
`default_nettype none

module rsx_mem_model
(
   input  wire logic       clk,
   input  wire logic [7:0] rd_addr,
   output logic      [7:0] rd_data,
   input  wire logic       we,
   input  wire logic [7:0] waddr,
   input  wire logic [7:0] wdata
);
   timeunit 1ns;
   timeprecision 100ps;

   // Byte-wide data memory, filled by the bench before each use
   logic [7:0] mem [256];

   // Operand offered in the issue cycle, no wait states modelled
   assign rd_data = mem[rd_addr];

   always @(posedge clk)
   begin
      if (we === 1'b1)
      begin
         mem[waddr] <= wdata;
      end
   end
endmodule : rsx_mem_model

`default_nettype wire

// >>> dv/tb.sv
`include "rsx_params.svh"
`default_nettype none

module tb
   import rsx_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // Design inputs driven by the bench
   logic        clk, resetn, issue_valid, irq_pending;
   rsx_op_t     issue_op;
   logic [7:0]  issue_imm, issue_addr;
   logic [2:0]  issue_bit, hsize;
   logic        hsel, hwrite;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata;
   // Design outputs and bus return
   wire  logic [7:0]  mem_rdata, mem_waddr_ff, mem_wdata_ff, acc_ff;
   wire  logic        issue_ready_ff, mem_we_ff, pop_pc_ff, skip_ff;
   wire  logic        irq_service_ff, master_irq_enable_ff;
   wire  logic        hreadyout_ff, hresp_ff, hready;
   wire  logic [31:0] hrdata_ff;
   // Scoreboard state
   logic [31:0] exp_q[$], rd_q[$];
   logic [31:0] got, e, rnd;
   logic        taken_d, rd_ph;
   int          num_errors, checked, cycles;
   // Bench copy of accumulator and flags
   logic [7:0]  acc_m;
   logic        c_m, ac_m, z_m, ov_m, mie_m;
   // Operand corner values: skip triggers and sign edges
   logic [7:0]  picks [4] = '{8'h01, 8'hff, 8'h00, 8'h80};
   logic [7:0]  ad, res_m;      // res_m: last result byte

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout_ff;

   rsx_exec i_dut (.clk(clk), .resetn(resetn),
      .issue_valid(issue_valid), .issue_op(issue_op),
      .issue_imm(issue_imm), .issue_bit(issue_bit),
      .issue_addr(issue_addr), .mem_rdata(mem_rdata),
      .irq_pending(irq_pending), .issue_ready_ff(issue_ready_ff),
      .mem_we_ff(mem_we_ff), .mem_waddr_ff(mem_waddr_ff),
      .mem_wdata_ff(mem_wdata_ff), .pop_pc_ff(pop_pc_ff),
      .skip_ff(skip_ff), .irq_service_ff(irq_service_ff),
      .acc_ff(acc_ff), .master_irq_enable_ff(master_irq_enable_ff),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout_ff(hreadyout_ff), .hrdata_ff(hrdata_ff),
      .hresp_ff(hresp_ff));

   rsx_mem_model i_mem (.clk(clk), .rd_addr(issue_addr),
      .rd_data(mem_rdata), .we(mem_we_ff), .waddr(mem_waddr_ff),
      .wdata(mem_wdata_ff));

   // Free-running 20 MHz clock
   always #25 clk = ~clk;

   function automatic logic [31:0] lfsr_nxt(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
   endfunction : lfsr_nxt

   // Expected status word from the bench flags
   function automatic logic [31:0] st_m();
      logic [31:0] s;
      s = 32'h0;
      s[`RSX_CARRY_BIT] = c_m;
      s[`RSX_HALF_BIT]  = ac_m;
      s[`RSX_ZERO_BIT]  = z_m;
      s[`RSX_OVF_BIT]   = ov_m;
      s[`RSX_MIE_BIT]   = mie_m;
      return s;
   endfunction : st_m

   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] expv);
      checked++;
      if (seen !== expv)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, expv, seen);
      end
   endtask : check

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // Single word transfer; called just after a rising edge
   task automatic ahb(input logic wr, input logic [31:0] a,
      input logic [31:0] d);
      issue_valid <= 1'b0;
      hsel        <= 1'b1;
      htrans      <= 2'b10;
      haddr       <= a;
      hwrite      <= wr;
      hsize       <= 3'b010;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
   endtask : ahb

   task automatic rd(input logic [31:0] a, input logic [31:0] expv);
      rd_q.push_back(expv);
      ahb(1'b0, a, 32'h0);
   endtask : rd

   // Offer one instruction and note its expected outcome
   task automatic issue(input rsx_op_t op, input logic [7:0] a,
      input logic [7:0] imm, input logic [2:0] bs, input logic irq);
      logic [7:0] m, r, b;
      logic [8:0] d9;
      logic [4:0] d5;
      logic       we, br, sk;
      m  = i_mem.mem[a];
      r  = m;
      b  = (op == OP_MINUS_LITERAL_TO_ACC) ? imm : m;
      br = (op inside {OP_MINUS_WITH_BORROW_TO_ACC,
         OP_MINUS_WITH_BORROW_TO_MEM}) ? ~c_m : 1'b0;
      we = op inside {OP_MEMORY_ROTATE_LEFT, OP_MEMORY_ROTATE_LEFT_CARRY,
         OP_MEMORY_ROTATE_RIGHT, OP_MEMORY_ROTATE_RIGHT_THRU_CY,
         OP_MINUS_WITH_BORROW_TO_MEM, OP_MINUS_MEMORY_TO_MEM,
         OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO, OP_SET_ALL,
         OP_SET_BIT, OP_NIBBLE_SWAP};
      case (op)
         OP_CALL_EXIT_LOAD_LITERAL: r = imm;
         OP_INTERRUPT_EXIT:
         begin
            // No result byte: the result register holds zero
            mie_m = 1'b1;
            r     = 8'h00;
         end
         OP_MEMORY_ROTATE_LEFT, OP_ACC_ROTATE_LEFT: r = {m[6:0], m[7]};
         OP_MEMORY_ROTATE_LEFT_CARRY,
         OP_ACC_ROTATE_LEFT_CARRY: {c_m, r} = {m, c_m};
         OP_MEMORY_ROTATE_RIGHT, OP_ACC_ROTATE_RIGHT: r = {m[0], m[7:1]};
         OP_MEMORY_ROTATE_RIGHT_THRU_CY,
         OP_ACC_ROTATE_RIGHT_THRU_CY: {r, c_m} = {c_m, m};
         OP_DECREMENT_SKIP_ZERO,
         OP_DECREMENT_TO_ACC_SKIP_ZERO: r = m - 8'h01;
         OP_INCREMENT_SKIP_ZERO,
         OP_INCREMENT_TO_ACC_SKIP_ZERO: r = m + 8'h01;
         OP_SET_ALL: r = 8'hff;
         OP_SET_BIT: r = m | (8'h01 << bs);
         OP_NIBBLE_SWAP: r = {m[3:0], m[7:4]};
         OP_MINUS_WITH_BORROW_TO_ACC, OP_MINUS_WITH_BORROW_TO_MEM,
         OP_MINUS_MEMORY_TO_ACC, OP_MINUS_MEMORY_TO_MEM,
         OP_MINUS_LITERAL_TO_ACC:
         begin
            // Borrow-in is the inverted carry, carry out means no borrow
            d9   = {1'b0, acc_m} - {1'b0, b} - 9'(br);
            d5   = {1'b0, acc_m[3:0]} - {1'b0, b[3:0]} - 5'(br);
            r    = d9[7:0];
            ov_m = (acc_m[7] != b[7]) && (r[7] != acc_m[7]);
            c_m  = ~d9[8];
            ac_m = ~d5[4];
            z_m  = (r == 8'h00);
         end
         default: r = m;
      endcase
      if (!we && !(op inside {OP_INTERRUPT_EXIT, OP_SKIP_BIT_NONZERO}))
         acc_m = r;
      res_m = r;
      sk = (op inside {OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO,
         OP_DECREMENT_TO_ACC_SKIP_ZERO, OP_INCREMENT_TO_ACC_SKIP_ZERO})
         ? (r == 8'h00) : (op == OP_SKIP_BIT_NONZERO) && m[bs];
      exp_q.push_back({acc_m, we ? r : 8'h00, we ? a : 8'h00, we, sk,
         ~sk, op inside {OP_CALL_EXIT_LOAD_LITERAL, OP_INTERRUPT_EXIT},
         (op == OP_INTERRUPT_EXIT) && irq, mie_m, 2'b00});
      issue_valid <= 1'b1;
      issue_op    <= op;
      issue_addr  <= a;
      issue_imm   <= imm;
      issue_bit   <= bs;
      irq_pending <= irq;
      do @(posedge clk); while (issue_ready_ff !== 1'b1);
   endtask : issue

   // Watcher: compares each answer with the oldest note
   always @(posedge clk)
   begin
      if (taken_d)
      begin
         e   = exp_q.pop_front();
         got = {acc_ff, mem_we_ff ? mem_wdata_ff : 8'h00,
            mem_we_ff ? mem_waddr_ff : 8'h00, mem_we_ff, skip_ff,
            issue_ready_ff, pop_pc_ff, irq_service_ff,
            master_irq_enable_ff, 2'b00};
         check("bytes", got & 32'hffff_ff00, e & 32'hffff_ff00);
         check("strobes", {24'h0, got[7:0]}, {24'h0, e[7:0]});
      end
      if (rd_ph && hready === 1'b1)
      begin
         rd_ph <= 1'b0;
         check("hresp", {31'h0, hresp_ff}, 32'h0);
         check("hrdata", hrdata_ff, rd_q.pop_front());
      end
      if (hsel && htrans[1] && hready === 1'b1 && !hwrite)
         rd_ph <= 1'b1;
      taken_d <= resetn && issue_valid && issue_ready_ff === 1'b1;
   end

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         give_verdict();
      end
   end

   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      issue_valid = 1'b0;
      issue_op = OP_SET_ALL;
      {issue_imm, issue_addr, issue_bit, irq_pending} = 20'h0;
      {hsel, hwrite, htrans, hsize, haddr, hwdata} = 71'h0;
      {taken_d, rd_ph, num_errors, checked, cycles} = '0;
      {acc_m, c_m, ac_m, z_m, ov_m, mie_m} = 13'h0;
      rnd = 32'hb90ad9d9;
      for (int i = 0; i < 256; i++) i_mem.mem[i] = 8'(i);
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(`RSX_ACC_OFS, 32'h0);
      rd(`RSX_STATUS_OFS, 32'h0);
      // Unmapped place: write dropped, read zero
      ahb(1'b1, 32'h0000_0010, 32'hffff_ffff);
      rd(32'h0000_0010, `RSX_UNMAPPED_RD);
      for (int n = 0; n < 230; n++)
      begin
         rnd = lfsr_nxt(rnd);
         ad  = rnd[7:0] & 8'hfe;
         i_mem.mem[ad] = (n < 92) ? picks[n / 23] : rnd[31:24];
         i_mem.mem[ad | 8'h01] = rnd[23:16];
         ahb(1'b1, `RSX_ACC_OFS, {24'h0, rnd[15:8]});
         acc_m = rnd[15:8];
         ahb(1'b1, `RSX_STATUS_OFS, {27'h0, rnd[28:24]});
         {mie_m, ov_m, z_m, ac_m, c_m} = rnd[28:24];
         // Two back to back, second held through any dummy slot
         issue(rsx_op_t'(5'(n % 23)), ad, rnd[31:24], rnd[22:20], rnd[19]);
         issue(rsx_op_t'(5'(rnd[11:0] % 23)), ad | 8'h01, rnd[7:0],
            rnd[26:24], rnd[17]);
         rd(`RSX_STATUS_OFS, st_m());
         rd(`RSX_ACC_OFS, {24'h0, acc_m});
         rd(`RSX_RESULT_OFS, {24'h0, res_m});
      end
      repeat (3) @(posedge clk);
      give_verdict();
   end
endmodule : tb

`default_nettype wire
